// file: hw/interrupt_vector_mapper.sv
/*
 Interrupt vector mapper: reset vector and highest-priority interrupt vector for the core.
 Assumes level requests held by peripherals until granted, and fuses stable while running.
*/
// Contract
// RQ1 - Reset vector is zero when boot fuse unprogrammed
// RQ2 - Programmed boot fuse sends reset to loader
// RQ3 - Relocate bit moves interrupt vectors to boot
// RQ4 - Relocated address is base plus boot start
// RQ5 - Extended layout: 28 vectors up to 0x036
// RQ6 - Compatible layout: 22 vectors up to 0x02A
// RQ7 - External requests 0..2 at 0x002..0x006
// RQ8 - Extended: pin change 0,1 at 0x008,0x00A
// RQ9 - Extended: timer three events 0x00C..0x012
// RQ10 - Transmit empty at 0x02A extended, 0x01E compatible
// RQ11 - Fuse level one unprogrammed, zero programmed
// RQ12 - Vectors start 0x0002 or boot plus 0x0002
// RQ13 - Lowest pending vector number is served first
`timescale 1ns/100ps
module interrupt_vector_mapper
   import vec_map_pkg::*;
(
   // Clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 rstn,
   // Fuses and control
   input  wire logic                 compat_layout_fuse,
   input  wire logic                 boot_reset_select_fuse,
   input  wire logic                 vector_relocate_bit,
   input  wire logic [ADDR_W-1:0]    boot_start_addr,
   // Peripheral requests and grants
   input  wire logic [SRC_CNT-1:0]   irq_req,
   output logic      [SRC_CNT-1:0]   irq_grant,
   // Core side
   input  wire logic                 vec_fetch,
   output logic      [ADDR_W-1:0]    reset_vec,
   output vec_out_t                  irq_vec
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [NUM_W-1:0] src_to_num(input int src, input logic compat);
      int n;
      n = src + 2;
      if (compat && src > CMP_GAP_LAST) begin
         n = src + 2 - CMP_GAP_LEN;
      end
      return NUM_W'(n);
   endfunction

   function automatic logic [ADDR_W-1:0] num_to_base(input logic [NUM_W-1:0] num);
      return ADDR_W'((num - RESET_NUM) * VEC_STEP);
   endfunction

   // ----------------------------------------------------------------
   // Next-value logic
   // ----------------------------------------------------------------
   logic                 compat;
   logic [SRC_CNT-1:0]   live_req;
   logic [ADDR_W-1:0]    reset_vec_d;
   logic [ADDR_W-1:0]    reset_vec_q;
   vec_out_t             irq_vec_d;
   vec_out_t             irq_vec_q;
   logic [SRC_CNT-1:0]   src_oh_d;
   logic [SRC_CNT-1:0]   src_oh_q;
   logic [SRC_CNT-1:0]   irq_grant_d;
   logic [SRC_CNT-1:0]   irq_grant_q;

   always_comb begin
      compat      = (compat_layout_fuse == FUSE_PROGRAMMED);
      live_req    = compat ? (irq_req & CMP_SRC_MASK) : irq_req;              // [RQ5] [RQ6]
      reset_vec_d = RESET_ADDR;                                               // [RQ1] [RQ11]
      if (boot_reset_select_fuse == FUSE_PROGRAMMED) begin
         reset_vec_d = boot_start_addr;                                       // [RQ2] [RQ11]
      end
      irq_vec_d = '0;
      src_oh_d  = '0;
      for (int s = SRC_CNT - 1; s >= 0; s--) begin
         if (live_req[s]) begin                                               // [RQ13]
            irq_vec_d.valid = 1'b1;
            irq_vec_d.num   = src_to_num(s, compat);                          // [RQ7] [RQ8] [RQ9] [RQ10]
            src_oh_d        = '0;
            src_oh_d[s]     = 1'b1;
         end
      end
      irq_vec_d.addr = num_to_base(irq_vec_d.num);                            // [RQ12]
      if (vector_relocate_bit) begin
         irq_vec_d.addr = irq_vec_d.addr + boot_start_addr;                   // [RQ3] [RQ4]
      end
      if (!irq_vec_d.valid) begin
         irq_vec_d.addr = '0;
      end
      irq_grant_d = '0;
      if (vec_fetch && irq_vec_q.valid) begin
         irq_grant_d = src_oh_q;
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         reset_vec_q <= RESET_ADDR;
         irq_vec_q   <= '0;
         src_oh_q    <= '0;
         irq_grant_q <= '0;
      end else begin
         reset_vec_q <= reset_vec_d;
         irq_vec_q   <= irq_vec_d;
         src_oh_q    <= src_oh_d;
         irq_grant_q <= irq_grant_d;
      end
   end

   assign reset_vec = reset_vec_q;
   assign irq_vec   = irq_vec_q;
   assign irq_grant = irq_grant_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   sequence s_only(int i);
      irq_req == (SRC_CNT'(1) << i) && !vector_relocate_bit;
   endsequence

   sequence s_ext_only(int i);
      s_only(i) and (compat_layout_fuse != FUSE_PROGRAMMED);
   endsequence

   sequence s_cmp_only(int i);
      s_only(i) and (compat_layout_fuse == FUSE_PROGRAMMED);
   endsequence

   property p_reset_zero;
      boot_reset_select_fuse != FUSE_PROGRAMMED |=> reset_vec == RESET_ADDR;
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("reset vector not zero"); // [RQ1]

   property p_reset_boot;
      boot_reset_select_fuse == FUSE_PROGRAMMED |=> reset_vec == $past(boot_start_addr);
   endproperty
   a_reset_boot: assert property (p_reset_boot) else $error("reset vector not boot address"); // [RQ2]

   property p_relocate;
      (irq_req != '0 && vector_relocate_bit) ##1 irq_vec.valid
         |-> irq_vec.addr == num_to_base(irq_vec.num) + $past(boot_start_addr);
   endproperty
   a_relocate: assert property (p_relocate) else $error("relocated vector wrong"); // [RQ4]

   property p_ext_range;
      compat_layout_fuse != FUSE_PROGRAMMED && !vector_relocate_bit && irq_req != '0
         |=> irq_vec.valid && irq_vec.addr <= ADDR_EXT_LAST && irq_vec.num <= NUM_W'(EXT_VEC_CNT);
   endproperty
   a_ext_range: assert property (p_ext_range) else $error("extended vector out of range"); // [RQ5]

   property p_cmp_range;
      compat_layout_fuse == FUSE_PROGRAMMED && !vector_relocate_bit && irq_vec_d.valid
         |=> irq_vec.addr <= ADDR_CMP_LAST && irq_vec.num <= NUM_W'(CMP_VEC_CNT);
   endproperty
   a_cmp_range: assert property (p_cmp_range) else $error("compatible vector out of range"); // [RQ6]

   property p_ext_irq;
      s_only(SRC_EXT_IRQ_2) |=> irq_vec.addr == ADDR_EXT_IRQ_2;
   endproperty
   a_ext_irq: assert property (p_ext_irq) else $error("external request 2 vector wrong"); // [RQ7]

   property p_pin_change;
      s_ext_only(SRC_PIN_CHANGE_1) |=> irq_vec.addr == ADDR_PIN_CHANGE_1;
   endproperty
   a_pin_change: assert property (p_pin_change) else $error("pin change vector wrong"); // [RQ8]

   property p_pin_change_gone;
      s_cmp_only(SRC_PIN_CHANGE_0) |=> !irq_vec.valid;
   endproperty
   a_pin_change_gone: assert property (p_pin_change_gone) else $error("pin change in compatible layout"); // [RQ6]

   property p_timer3;
      s_ext_only(SRC_TIMER3_OVERFLOW) |=> irq_vec.addr == ADDR_T3_OVERFLOW;
   endproperty
   a_timer3: assert property (p_timer3) else $error("timer three overflow vector wrong"); // [RQ9]

   property p_txe;
      (s_ext_only(SRC_TX_BUF_EMPTY_0) |=> irq_vec.addr == ADDR_TXE_EXT) and
      (s_cmp_only(SRC_TX_BUF_EMPTY_0) |=> irq_vec.addr == ADDR_TXE_CMP);
   endproperty
   a_txe: assert property (p_txe) else $error("transmit empty vector wrong"); // [RQ10]

   property p_priority;
      irq_req[SRC_EXT_IRQ_0] ##1 vec_fetch |=> irq_grant[SRC_EXT_IRQ_0] && $onehot(irq_grant);
   endproperty
   a_priority: assert property (p_priority) else $error("lowest vector not served first"); // [RQ13]

endmodule

// file: hw/vec_map_pkg.sv
/*
 Constants, source indices and carrier types for the interrupt vector mapper.
 Assumes program addresses are word addresses and fuse levels are raw (0 = programmed).
*/
package vec_map_pkg;

   // ----------------------------------------------------------------
   // Widths and layout figures
   // ----------------------------------------------------------------
   localparam int ADDR_W        = 16;
   localparam int NUM_W         = 5;
   localparam int SRC_CNT       = 27;
   localparam int EXT_VEC_CNT   = 28;
   localparam int CMP_VEC_CNT   = 22;
   localparam int VEC_STEP      = 2;
   localparam logic [ADDR_W-1:0] RESET_ADDR = 16'h0000;
   localparam logic [NUM_W-1:0]  RESET_NUM  = 5'h01;
   localparam logic FUSE_PROGRAMMED = 1'b0;

   // ----------------------------------------------------------------
   // Source indices, extended-layout order
   // ----------------------------------------------------------------
   localparam int SRC_EXT_IRQ_0       = 0;
   localparam int SRC_EXT_IRQ_1       = 1;
   localparam int SRC_EXT_IRQ_2       = 2;
   localparam int SRC_PIN_CHANGE_0    = 3;
   localparam int SRC_PIN_CHANGE_1    = 4;
   localparam int SRC_TIMER3_CAPTURE  = 5;
   localparam int SRC_TIMER3_OVERFLOW = 8;
   localparam int SRC_TX_BUF_EMPTY_0  = 20;
   // Sources 3..8 exist only in the extended layout.
   localparam int CMP_GAP_FIRST       = 3;
   localparam int CMP_GAP_LAST        = 8;
   localparam int CMP_GAP_LEN         = 6;
   localparam logic [SRC_CNT-1:0] CMP_SRC_MASK = 27'h7FFFE07;

   // ----------------------------------------------------------------
   // Vector addresses; all but ADDR_EXT_IRQ_0, ADDR_EXT_IRQ_1, ADDR_PIN_CHANGE_0 and ADDR_T3_CAPTURE are checked directly
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] ADDR_EXT_IRQ_0    = 16'h0002;
   localparam logic [ADDR_W-1:0] ADDR_EXT_IRQ_1    = 16'h0004;
   localparam logic [ADDR_W-1:0] ADDR_EXT_IRQ_2    = 16'h0006;
   localparam logic [ADDR_W-1:0] ADDR_PIN_CHANGE_0 = 16'h0008;
   localparam logic [ADDR_W-1:0] ADDR_PIN_CHANGE_1 = 16'h000A;
   localparam logic [ADDR_W-1:0] ADDR_T3_CAPTURE   = 16'h000C;
   localparam logic [ADDR_W-1:0] ADDR_T3_OVERFLOW  = 16'h0012;
   localparam logic [ADDR_W-1:0] ADDR_TXE_EXT      = 16'h002A;
   localparam logic [ADDR_W-1:0] ADDR_TXE_CMP      = 16'h001E;
   localparam logic [ADDR_W-1:0] ADDR_EXT_LAST     = 16'h0036;
   localparam logic [ADDR_W-1:0] ADDR_CMP_LAST     = 16'h002A;

   // ----------------------------------------------------------------
   // Carrier for the vector offered to the core
   // ----------------------------------------------------------------
   typedef struct packed {
      logic              valid;
      logic [NUM_W-1:0]  num;
      logic [ADDR_W-1:0] addr;
   } vec_out_t;

endpackage

// file: verif/core_model.sv
/*
 Behavioural model of the core that fetches interrupt vectors.
 Assumes the mapper offers a registered vector and grants the fetched source one cycle later.
*/
`timescale 1ns/100ps
module core_model
   import vec_map_pkg::*;
(
   // Clock and control
   input  wire logic       clk_sys,
   input  wire logic       rstn,
   input  wire logic       en,
   input  wire logic [1:0] lag,
   // Vector side
   input  wire vec_out_t   irq_vec,
   output logic            vec_fetch
);
   logic [1:0] cnt;
   // Fetches once a vector has stood lag cycles; the pulse lasts one cycle when lag is nonzero, and repeats every cycle while valid when lag is 0.
   always @(negedge clk_sys) begin
      if (!rstn || !en) begin
         vec_fetch = 1'b0;
         cnt       = 2'h0;
      end else if (irq_vec.valid && cnt >= lag) begin
         vec_fetch = 1'b1;
         cnt       = 2'h0;
      end else begin
         vec_fetch = 1'b0;
         if (irq_vec.valid) cnt = cnt + 2'h1;
      end
   end
endmodule

// file: verif/tb_interrupt_vector_mapper.sv
/*
 Self-checking testbench for the interrupt vector mapper with a core model.
 Assumes results appear one rising edge after inputs are set at a falling edge.
*/
`timescale 1ns/100ps
module tb_interrupt_vector_mapper;
   import vec_map_pkg::*;
   logic                clk_sys = 1'b0;
   logic                rstn    = 1'b0;
   logic                compat_layout_fuse = 1'b1;
   logic                boot_reset_select_fuse = 1'b1;
   logic                vector_relocate_bit = 1'b0;
   logic [ADDR_W-1:0]   boot_start_addr = 16'h1C00;
   logic [SRC_CNT-1:0]  irq_req = '0;
   logic [SRC_CNT-1:0]  irq_grant;
   logic                vec_fetch;
   logic [ADDR_W-1:0]   reset_vec;
   vec_out_t            irq_vec;
   logic                core_en = 1'b0;
   logic [1:0]          core_lag = 2'h1;
   int                  n_errors = 0;
   int                  n_compared = 0;
   int                  cyc = 0;

   always #12.5 clk_sys = ~clk_sys;

   interrupt_vector_mapper dut_u (.clk_sys(clk_sys), .rstn(rstn), .compat_layout_fuse(compat_layout_fuse),
      .boot_reset_select_fuse(boot_reset_select_fuse), .vector_relocate_bit(vector_relocate_bit),
      .boot_start_addr(boot_start_addr), .irq_req(irq_req), .irq_grant(irq_grant),
      .vec_fetch(vec_fetch), .reset_vec(reset_vec), .irq_vec(irq_vec));
   core_model core_u (.clk_sys(clk_sys), .rstn(rstn), .en(core_en), .lag(core_lag),
      .irq_vec(irq_vec), .vec_fetch(vec_fetch));

   task automatic close_out;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         close_out();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   function automatic vec_out_t exp_vec(input int s, input logic cmp, input logic rel);
      vec_out_t e;
      int       n;
      e = '0;
      if (cmp && s >= 3 && s <= 8) return e;
      n = (cmp && s > 8) ? s - 4 : s + 2;
      e.valid = 1'b1;
      e.num   = n[4:0];
      e.addr  = 16'((n - 1) * 2) + (rel ? boot_start_addr : 16'h0000);
      return e;
   endfunction

   task automatic t_reset;
      boot_reset_select_fuse = 1'b0;
      @(negedge clk_sys);
      chk(reset_vec, boot_start_addr);
      boot_reset_select_fuse = 1'b1;
      vector_relocate_bit = 1'b1;
      @(negedge clk_sys);
      chk(reset_vec, 16'h0000);
      vector_relocate_bit = 1'b0;
      $display("test reset vector done");
   endtask

   task automatic t_map;
      for (int m = 0; m < 4; m++) begin
         compat_layout_fuse  = m[1];
         vector_relocate_bit = m[0];
         for (int s = 0; s < SRC_CNT; s++) begin
            irq_req = '0;
            irq_req[s] = 1'b1;
            @(negedge clk_sys);
            chk(irq_vec, exp_vec(s, !m[1], m[0]));
         end
      end
      irq_req = '0;
      vector_relocate_bit = 1'b0;
      $display("test vector map done");
   endtask

   task automatic t_grant(input logic cmp, input logic [1:0] lg, input int s0, input int s1, input int s2);
      int q[3];
      q = '{s0, s1, s2};
      compat_layout_fuse = !cmp;
      irq_req = '0;
      foreach (q[k]) irq_req[q[k]] = 1'b1;
      @(negedge clk_sys);
      chk(irq_vec, exp_vec(cmp && s0 >= 3 && s0 <= 8 ? s1 : s0, cmp, 1'b0));
      core_lag = lg;
      core_en  = 1'b1;
      foreach (q[k]) begin
         if (!(cmp && q[k] >= 3 && q[k] <= 8)) begin
            @(negedge clk_sys);
            for (int i = 0; i < 8 && irq_grant === '0; i++) @(negedge clk_sys);
            chk(irq_grant, 32'h1 << q[k]);
            irq_req[q[k]] = 1'b0;
         end
      end
      repeat (3) @(negedge clk_sys);
      chk(irq_vec, 32'h0);
      core_en = 1'b0;
      irq_req = '0;
      @(negedge clk_sys);
      $display("test grant order done");
   endtask

   task automatic t_mid_reset;
      boot_reset_select_fuse = 1'b0;
      irq_req = '0;
      irq_req[SRC_EXT_IRQ_2] = 1'b1;
      @(negedge clk_sys);
      rstn = 1'b0;
      @(negedge clk_sys);
      chk(reset_vec, 16'h0000);
      chk(irq_vec, 32'h0);
      chk(irq_grant, 32'h0);
      rstn = 1'b1;
      @(negedge clk_sys);
      chk(reset_vec, boot_start_addr);
      chk(irq_vec, exp_vec(SRC_EXT_IRQ_2, !compat_layout_fuse, 1'b0));
      irq_req = '0;
      boot_reset_select_fuse = 1'b1;
      @(negedge clk_sys);
      $display("test mid-run reset done");
   endtask

   initial begin
      boot_reset_select_fuse = 1'b0;
      repeat (16) @(negedge clk_sys);
      chk(reset_vec, 16'h0000);
      boot_reset_select_fuse = 1'b1;
      rstn = 1'b1;
      @(negedge clk_sys);
      t_reset();
      t_map();
      t_grant(1'b0, 2'h1, SRC_EXT_IRQ_0, SRC_TIMER3_CAPTURE, SRC_TX_BUF_EMPTY_0);
      t_grant(1'b1, 2'h2, SRC_PIN_CHANGE_0, 9, 24);
      t_mid_reset();
      close_out();
   end
endmodule
